// >>> src/gpwl_wake_logic.sv
// Wake logic: general-purpose ports, wake status from edges and the fan level, wake output and key detector.
// Assumes all inputs are synchronous to aclk and an AXI4-Lite master on the register side.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "gpwl_cfg.svh"
module gpwl_wake_logic
    import gpwl_pkg::*;
#(
    parameter int unsigned KEY_IDLE_CYCLES =
        (`GPWL_KEY_IDLE_US * 1000 + `GPWL_CLK_PERIOD_NS - 1) / `GPWL_CLK_PERIOD_NS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic standby_por_n,
    input wire logic ce,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [`GPWL_NUM_PORTS-1:0] port_pins_in,
    output gpwl_port_drive_t port_drive,
    input wire logic ring_indicate_a_n,
    input wire logic ring_indicate_b_n,
    input wire logic kbd_data_in,
    input wire logic mouse_data_in,
    input wire logic fan_event,
    input wire logic kbd_clk_in,
    output gpwl_wake_drive_t wake_event_out
);

    localparam logic [15:0] IDLE_CNT = 16'(KEY_IDLE_CYCLES);
    localparam logic [9:0] PORT_CFG_END = `GPWL_IDX_PORT_CFG + 10'(`GPWL_NUM_PORTS);

    gpwl_state_t s;
    gpwl_state_t next_s;
    logic [`GPWL_NUM_PORTS-1:0] dir_v;
    logic [`GPWL_NUM_PORTS-1:0] pol_v;
    logic [`GPWL_NUM_PORTS-1:0] drv_v;
    logic [`GPWL_NUM_PORTS-1:0] dual_mask;
    logic [`GPWL_NUM_PORTS-1:0] rise;
    logic [`GPWL_NUM_PORTS-1:0] fall;
    logic [`GPWL_NUM_PORTS-1:0] port_ev;
    logic [`GPWL_NUM_PORTS-1:0] read_view;
    logic [`GPWL_NUM_PORTS-1:0] writable;
    logic [`GPWL_NUM_PORTS-1:0] out_level;
    logic [7:0] src1;
    logic [1:0] misc_ev;
    logic [9:0] widx;
    logic [9:0] ridx;
    logic [3:0] wport;
    logic [3:0] rport;
    logic wr_fire;
    logic wr_en;
    logic wr_hit;
    logic rd_fire;
    logic rd_hit;
    logic [7:0] rbyte;
    logic [7:0] wbyte;
    logic kfall;
    logic khigh;
    logic kdat;
    logic idle_met;
    logic key_hit;
    logic wake_level;

    // Handshakes are combinational; gating with ce keeps a frozen block from dropping a beat.
    assign wr_fire = ce & awvalid & wvalid & ~s.bvalid;
    assign rd_fire = ce & arvalid & ~s.rvalid;
    assign awready = wr_fire;
    assign wready = wr_fire;
    assign arready = ce & ~s.rvalid;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = s.rdata;

    always_comb begin
        for (int i = 0; i < `GPWL_NUM_PORTS; i++) begin
            dir_v[i] = s.port_cfg[i][`GPWL_CFG_DIR];
            pol_v[i] = s.port_cfg[i][`GPWL_CFG_POL];
            drv_v[i] = s.port_cfg[i][`GPWL_CFG_DRV];
        end
        dual_mask = 12'(s.dual_sel) << `GPWL_DUAL_LSB;
        // A selected dual-edge pin behaves as an input whatever its direction bit says.
        writable = ~dir_v & ~dual_mask;
        out_level = s.port_out ^ pol_v;
        read_view = ((port_pins_in ^ pol_v) & ~writable) | (s.port_out & writable);
        for (int i = 0; i < `GPWL_NUM_PORTS; i++) begin
            port_drive.oe[i] = writable[i] & (drv_v[i] | ~out_level[i]);
            port_drive.level[i] = writable[i] & drv_v[i] & out_level[i];
        end
        wake_level = s.wake_active ? s.wake_output_config[`GPWL_WAKE_POL]
                                   : ~s.wake_output_config[`GPWL_WAKE_POL];
        wake_event_out.oe = s.wake_output_config[`GPWL_WAKE_DRV] | ~wake_level;
        wake_event_out.level = s.wake_output_config[`GPWL_WAKE_DRV] & wake_level;
    end

    always_comb begin
        next_s = s;
        widx = awaddr[11:2];
        ridx = araddr[11:2];
        wport = 4'(widx - `GPWL_IDX_PORT_CFG);
        rport = 4'(ridx - `GPWL_IDX_PORT_CFG);
        wr_en = wr_fire & wstrb[0];
        wbyte = wdata[7:0];

        // Port edges.
        rise = port_pins_in & ~s.pin_prev;
        fall = ~port_pins_in & s.pin_prev;
        next_s.pin_prev = port_pins_in;
        for (int i = 0; i < `GPWL_NUM_PORTS; i++) begin
            port_ev[i] = dir_v[i] & (pol_v[i] ? fall[i] : rise[i]);
        end
        for (int k = 0; k < 2; k++) begin
            misc_ev[k] = rise[`GPWL_DUAL_LSB + k] | fall[`GPWL_DUAL_LSB + k];
            if (s.dual_sel[k]) begin
                port_ev[`GPWL_DUAL_LSB + k] = misc_ev[k];
            end
        end

        // Other wake sources; ring indicators are active low, so their falling edge counts.
        next_s.src_prev = {mouse_data_in, kbd_data_in, ring_indicate_b_n, ring_indicate_a_n};
        src1 = 8'h00;
        src1[`GPWL_ST1_RI_A] = s.src_prev[0] & ~ring_indicate_a_n;
        src1[`GPWL_ST1_RI_B] = s.src_prev[1] & ~ring_indicate_b_n;
        src1[`GPWL_ST1_KBD] = s.src_prev[2] & ~kbd_data_in;
        src1[`GPWL_ST1_MOUSE] = s.src_prev[3] & ~mouse_data_in;
        src1[`GPWL_ST1_FAN] = fan_event;

        // Key detector on the keyboard lines.
        next_s.kclk_sync = {s.kclk_sync[1], s.kclk_sync[0], kbd_clk_in};
        next_s.kdat_sync = {s.kdat_sync[0], kbd_data_in};
        kfall = s.kclk_sync[2] & ~s.kclk_sync[1];
        khigh = s.kclk_sync[1];
        kdat = s.kdat_sync[1];
        idle_met = s.high_cnt >= IDLE_CNT;
        key_hit = 1'b0;
        if (!khigh) begin
            next_s.high_cnt = 16'h0000;
        end else if (!idle_met) begin
            next_s.high_cnt = s.high_cnt + 16'h0001;
        end
        if (s.slow_clock_config[`GPWL_SLOW_KEY_OFF]) begin
            // Disabled detector sits in KEY_OFF with high_cnt and bit_cnt cleared.
            next_s.kstate = KEY_OFF;
            next_s.high_cnt = 16'h0000;
            next_s.bit_cnt = 4'h0;
        end else begin
            unique case (s.kstate)
                KEY_OFF: begin
                    next_s.kstate = KEY_WAIT_IDLE;
                end
                KEY_WAIT_IDLE: begin
                    if (kfall && idle_met) begin
                        next_s.kstate = KEY_FRAME;
                        next_s.bit_cnt = 4'h1;
                        next_s.shift = 9'h000;
                    end
                end
                KEY_FRAME: begin
                    if (idle_met) begin
                        // Already idle long enough, so the next falling edge opens a new frame.
                        next_s.kstate = KEY_WAIT_IDLE;
                    end else if (kfall) begin
                        if (s.bit_cnt == 4'ha) begin
                            key_hit = kdat && (s.shift[7:0] == s.key_match_code)
                                      && (^s.shift);
                            next_s.kstate = KEY_WAIT_IDLE;
                        end else begin
                            next_s.shift = {kdat, s.shift[8:1]};
                            next_s.bit_cnt = s.bit_cnt + 4'h1;
                        end
                    end
                end
            endcase
        end
        src1[`GPWL_ST1_KEY] = key_hit;

        // Status bits: a set in the same cycle as a clear wins.
        next_s.st1 = (s.st1 & ~((wr_en && widx == `GPWL_IDX_ST1) ? wbyte : 8'h00)) | src1;
        next_s.st2 = (s.st2 & ~((wr_en && widx == `GPWL_IDX_ST2) ? wbyte : 8'h00))
                     | port_ev[7:0];
        next_s.st3 = (s.st3 & ~((wr_en && widx == `GPWL_IDX_ST3) ? wbyte[3:0] : 4'h0))
                     | port_ev[11:8];
        next_s.misc_edge_status = (s.misc_edge_status
                                   & ~((wr_en && widx == `GPWL_IDX_MISC) ? wbyte[1:0] : 2'h0))
                                  | misc_ev;
        next_s.wake_active = s.global_wake_enable
                             & (|(s.st1 & s.en1) | |(s.st2 & s.en2) | |(s.st3 & s.en3));

        // Register writes.
        wr_hit = 1'b1;
        if (widx >= `GPWL_IDX_PORT_CFG && widx < PORT_CFG_END) begin
            if (wr_en) begin
                next_s.port_cfg[wport] = wbyte;
            end
        end else begin
            unique case (widx)
                `GPWL_IDX_KEY_CODE: if (wr_en) next_s.key_match_code = wbyte;
                `GPWL_IDX_WAKE_CFG: if (wr_en) next_s.wake_output_config = wbyte;
                `GPWL_IDX_SLOW_CFG: if (wr_en) next_s.slow_clock_config = wbyte;
                `GPWL_IDX_DATA1: begin
                    if (wr_en) begin
                        next_s.port_out[7:0] = (wbyte & writable[7:0])
                                               | (s.port_out[7:0] & ~writable[7:0]);
                    end
                end
                `GPWL_IDX_DATA2: begin
                    if (wr_en) begin
                        next_s.port_out[11:8] = (wbyte[3:0] & writable[11:8])
                                                | (s.port_out[11:8] & ~writable[11:8]);
                    end
                end
                `GPWL_IDX_EN1: if (wr_en) next_s.en1 = wbyte;
                `GPWL_IDX_EN2: if (wr_en) next_s.en2 = wbyte;
                `GPWL_IDX_EN3: if (wr_en) next_s.en3 = wbyte[3:0];
                `GPWL_IDX_GEN: if (wr_en) next_s.global_wake_enable = wbyte[0];
                `GPWL_IDX_DUAL: if (wr_en) next_s.dual_sel = wbyte[1:0];
                `GPWL_IDX_ST1, `GPWL_IDX_ST2, `GPWL_IDX_ST3, `GPWL_IDX_MISC: wr_hit = 1'b1;
                default: wr_hit = 1'b0;
            endcase
        end
        if (wr_fire) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = wr_hit ? `GPWL_RESP_OKAY : `GPWL_RESP_SLVERR;
        end else if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end

        // Register reads; an input port's pin level is caught at the read.
        rd_hit = 1'b1;
        rbyte = 8'h00;
        if (ridx >= `GPWL_IDX_PORT_CFG && ridx < PORT_CFG_END) begin
            rbyte = s.port_cfg[rport];
        end else begin
            unique case (ridx)
                `GPWL_IDX_KEY_CODE: rbyte = s.key_match_code;
                `GPWL_IDX_WAKE_CFG: rbyte = s.wake_output_config;
                `GPWL_IDX_SLOW_CFG: rbyte = s.slow_clock_config;
                `GPWL_IDX_DATA1: rbyte = read_view[7:0];
                `GPWL_IDX_DATA2: rbyte = {4'h0, read_view[11:8]};
                `GPWL_IDX_ST1: rbyte = s.st1;
                `GPWL_IDX_EN1: rbyte = s.en1;
                `GPWL_IDX_ST2: rbyte = s.st2;
                `GPWL_IDX_EN2: rbyte = s.en2;
                `GPWL_IDX_ST3: rbyte = {4'h0, s.st3};
                `GPWL_IDX_EN3: rbyte = {4'h0, s.en3};
                `GPWL_IDX_GEN: rbyte = {7'h00, s.global_wake_enable};
                `GPWL_IDX_MISC: rbyte = {6'h00, s.misc_edge_status};
                `GPWL_IDX_DUAL: rbyte = {6'h00, s.dual_sel};
                default: rd_hit = 1'b0;
            endcase
        end
        if (rd_fire) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = {24'h000000, rbyte};
            next_s.rresp = rd_hit ? `GPWL_RESP_OKAY : `GPWL_RESP_SLVERR;
        end else if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    // The key code lives on standby power, so only the standby reset clears it.
    always_ff @(posedge aclk) begin
        if (!standby_por_n) begin
            s <= '0;
            s.port_cfg <= {`GPWL_NUM_PORTS{`GPWL_PORT_CFG_RST}};
            s.wake_output_config <= `GPWL_WAKE_CFG_RST;
            s.slow_clock_config <= `GPWL_SLOW_CFG_RST;
            s.key_match_code <= `GPWL_KEY_CODE_RST;
        end else if (!aresetn) begin
            s <= '0;
            s.port_cfg <= {`GPWL_NUM_PORTS{`GPWL_PORT_CFG_RST}};
            s.wake_output_config <= `GPWL_WAKE_CFG_RST;
            s.slow_clock_config <= `GPWL_SLOW_CFG_RST;
            s.key_match_code <= s.key_match_code;
        end else if (ce) begin
            s <= next_s;
        end
    end

endmodule : gpwl_wake_logic
`default_nettype wire

// >>> src/gpwl_cfg.svh
// Constants of the wake logic: register indices, field positions, resets, timing.
// Assumes a 100 MHz clock; a register index times four is its AXI4-Lite byte address.
// How it works
// - Port config: bit0 direction, bit1 polarity, bit7 driver.
// - Input port reads pin, writes ignored.
// - Output port drives written bit, reads back it.
// - Output ports never raise wake events.
// - Twelve ports wake; polarity selects active edge.
// - Group one in pair two, group two pair three.
// - Wake output needs global enable plus source enable.
// - Status bits set regardless of global enable.
// - Port status clears only on written one.
// - Wake stays active until enabled statuses cleared.
// - Dual-edge pins set status on both edges.
// - Dual-edge ignores config, polarity still inverts data.
// - Dual-edge events also set misc status bits.
// - Ring, keyboard, mouse, port and fan events wake.
// - Wake output polarity and driver type programmable.
// - Key code register resets on standby reset only.
// - Key match sets status one bit five.
// - Frame starts at falling edge after long idle.
// - Match needs byte, odd parity, stop one.
// - Detector restarts after eleven clocks, until disabled.
// - Detector aborts when clock stays high too long.
// - Slow clock config bit one stops key detector.
`ifndef GPWL_CFG_SVH
`define GPWL_CFG_SVH
`define GPWL_CLK_PERIOD_NS 10
`define GPWL_KEY_IDLE_US 115
`define GPWL_NUM_PORTS 12
`define GPWL_DUAL_LSB 9
`define GPWL_IDX_KEY_CODE 10'h011
`define GPWL_IDX_WAKE_CFG 10'h016
`define GPWL_IDX_SLOW_CFG 10'h0f0
`define GPWL_IDX_PORT_CFG 10'h020
`define GPWL_IDX_DATA1 10'h030
`define GPWL_IDX_DATA2 10'h031
`define GPWL_IDX_ST1 10'h040
`define GPWL_IDX_EN1 10'h041
`define GPWL_IDX_ST2 10'h042
`define GPWL_IDX_EN2 10'h043
`define GPWL_IDX_ST3 10'h044
`define GPWL_IDX_EN3 10'h045
`define GPWL_IDX_GEN 10'h046
`define GPWL_IDX_MISC 10'h047
`define GPWL_IDX_DUAL 10'h048
`define GPWL_CFG_DIR 0
`define GPWL_CFG_POL 1
`define GPWL_CFG_DRV 7
`define GPWL_WAKE_POL 0
`define GPWL_WAKE_DRV 7
`define GPWL_SLOW_KEY_OFF 1
`define GPWL_ST1_RI_A 0
`define GPWL_ST1_RI_B 1
`define GPWL_ST1_KBD 2
`define GPWL_ST1_MOUSE 3
`define GPWL_ST1_FAN 4
`define GPWL_ST1_KEY 5
`define GPWL_PORT_CFG_RST 8'h01
`define GPWL_WAKE_CFG_RST 8'h00
`define GPWL_SLOW_CFG_RST 8'h00
`define GPWL_KEY_CODE_RST 8'h00
`define GPWL_RESP_OKAY 2'h0
`define GPWL_RESP_SLVERR 2'h2
`endif

// >>> src/gpwl_pkg.sv
// Types shared by the wake logic: pin carriers, detector states and the state record.
// Assumes gpwl_cfg.svh is on the include path.
`include "gpwl_cfg.svh"
package gpwl_pkg;
    typedef enum logic [1:0] {KEY_OFF, KEY_WAIT_IDLE, KEY_FRAME} gpwl_key_state_t;
    typedef struct packed {
        logic [`GPWL_NUM_PORTS-1:0] level;
        logic [`GPWL_NUM_PORTS-1:0] oe;
    } gpwl_port_drive_t;
    typedef struct packed {
        logic level;
        logic oe;
    } gpwl_wake_drive_t;
    typedef struct packed {
        logic [`GPWL_NUM_PORTS-1:0][7:0] port_cfg;
        logic [`GPWL_NUM_PORTS-1:0] port_out;
        logic [`GPWL_NUM_PORTS-1:0] pin_prev;
        logic [7:0] st1;
        logic [7:0] en1;
        logic [7:0] st2;
        logic [7:0] en2;
        logic [3:0] st3;
        logic [3:0] en3;
        logic global_wake_enable;
        logic [1:0] misc_edge_status;
        logic [1:0] dual_sel;
        logic [7:0] key_match_code;
        logic [7:0] wake_output_config;
        logic [7:0] slow_clock_config;
        logic [3:0] src_prev;
        logic wake_active;
        logic [2:0] kclk_sync;
        logic [1:0] kdat_sync;
        gpwl_key_state_t kstate;
        logic [15:0] high_cnt;
        logic [3:0] bit_cnt;
        logic [8:0] shift;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } gpwl_state_t;
endpackage : gpwl_pkg

// >>> sim/gpwl_chipset_model.sv
// Chipset side of the wake output: the board pull-up resolves the pin.
// Assumes the design drives level and enable of the wake pin.
`timescale 1ns/10ps
`default_nettype none
module gpwl_chipset_model
    import gpwl_pkg::*;
(
    input wire gpwl_wake_drive_t wake_event_out,
    output logic wake_line
);
    // A released open-drain pin floats to the pull-up, never to the last value.
    assign wake_line = wake_event_out.oe ? wake_event_out.level : 1'b1;
endmodule : gpwl_chipset_model
`default_nettype wire

// >>> sim/gpwl_wake_logic_monitor.sv
// Checker of the wake logic ports: bus handshake, responses and output stability.
// Assumes it is bound to gpwl_wake_logic and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "gpwl_cfg.svh"
module gpwl_monitor
    import gpwl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic standby_por_n,
    input wire logic ce,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire gpwl_port_drive_t port_drive,
    input wire gpwl_wake_drive_t wake_event_out
);
    function automatic logic [1:0] resp_of(input logic [11:0] a);
        logic [9:0] i;
        i = a[11:2];
        if (i inside {`GPWL_IDX_KEY_CODE, `GPWL_IDX_WAKE_CFG, `GPWL_IDX_SLOW_CFG,
            [`GPWL_IDX_PORT_CFG:10'h02b], `GPWL_IDX_DATA1, `GPWL_IDX_DATA2,
            [`GPWL_IDX_ST1:`GPWL_IDX_DUAL]}) return `GPWL_RESP_OKAY;
        return `GPWL_RESP_SLVERR;
    endfunction : resp_of
    default clocking @(posedge aclk); endclocking
    default disable iff (!(aresetn && standby_por_n));
    sequence s_wtake; awvalid && awready && wvalid && wready; endsequence
    sequence s_rtake; arvalid && arready; endsequence
    property p_aw_ready; awready == (ce && awvalid && wvalid && !bvalid) && wready == awready; endproperty
    a_aw_ready: assert property (p_aw_ready) else $error("write ready wrong");
    property p_ar_ready; arready == (ce && !rvalid); endproperty
    a_ar_ready: assert property (p_ar_ready) else $error("read ready wrong");
    property p_wr_resp; s_wtake |=> bvalid && bresp == resp_of($past(awaddr)); endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response wrong");
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_resp;
        s_rtake |=> rvalid && rresp == resp_of($past(araddr)) && rdata[31:8] == 24'h000000;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read response wrong");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_ce_freeze;
        !ce |=> $stable(bvalid) && $stable(rvalid) && $stable(port_drive) && $stable(wake_event_out);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while halted");
    // Either reset returns every port to input, so a reset edge may also move the pin drive.
    property p_drive_cause;
        !$stable(port_drive) |-> $past((awvalid && awready && wvalid) || !aresetn || !standby_por_n);
    endproperty
    a_drive_cause: assert property (p_drive_cause) else $error("pin drive moved unasked");
endmodule : gpwl_monitor
bind gpwl_wake_logic gpwl_monitor u_mon (
    .aclk(aclk), .aresetn(aresetn), .standby_por_n(standby_por_n), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .port_drive(port_drive), .wake_event_out(wake_event_out)
);
`default_nettype wire

// >>> sim/gpwl_wake_logic_tb.sv
// Bench of the wake logic: registers over AXI4-Lite, port and source events, key frames.
// Assumes the bound checker and the chipset model with its pull-up on the wake pin.
`timescale 1ns/10ps
`default_nettype none
`include "gpwl_cfg.svh"
module gpwl_wake_logic_tb
    import gpwl_pkg::*;
;
    // A short idle count keeps each key frame to a few hundred cycles.
    localparam int KIDLE = 50;
    logic aclk = 1'b0, aresetn = 1'b0, standby_por_n = 1'b0, ce = 1'b1, kclk = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000, pins = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [4:0] src = 5'h0f;
    logic awready, wready, bvalid, arready, rvalid, wake_line;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rv;
    gpwl_port_drive_t port_drive;
    gpwl_wake_drive_t wake_event_out;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    always #5 aclk = ~aclk;
    gpwl_wake_logic #(.KEY_IDLE_CYCLES(KIDLE)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .standby_por_n(standby_por_n), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .port_pins_in(pins), .port_drive(port_drive),
        .ring_indicate_a_n(src[0]), .ring_indicate_b_n(src[1]), .kbd_data_in(src[2]),
        .mouse_data_in(src[3]), .fan_event(src[4]), .kbd_clk_in(kclk),
        .wake_event_out(wake_event_out)
    );
    gpwl_chipset_model u_host (.wake_event_out(wake_event_out), .wake_line(wake_line));
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask : idle
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rchk(input string nm, input logic [9:0] idx, input logic [7:0] e);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
        chk(nm, rv, {24'h000000, e});
    endtask : rchk
    // Sends the first n bits of a frame with byte 8'h5a; a parity bit of 1 makes the frame odd.
    task automatic kframe(input logic par, input int n);
        logic [10:0] f;
        f = {1'b1, par, 8'h5a, 1'b0};
        idle(KIDLE + 10);
        for (int i = 0; i < n; i++) begin
            src[2] <= f[i];
            idle(8);
            kclk <= 1'b0;
            idle(8);
            kclk <= 1'b1;
        end
        idle(KIDLE + 10);
    endtask : kframe
    initial begin
        idle(2);
        aresetn <= 1'b1;
        standby_por_n <= 1'b1;
        rchk("wake cfg", `GPWL_IDX_WAKE_CFG, 8'h00);
        rchk("slow cfg", `GPWL_IDX_SLOW_CFG, 8'h00);
        rchk("port cfg", `GPWL_IDX_PORT_CFG + 10'h00b, 8'h01);
        rchk("hole", 10'h3ff, 8'h00);
        chk("hole rresp", rs, `GPWL_RESP_SLVERR);
        wr(10'h3ff, 8'hff);
        chk("hole bresp", rs, `GPWL_RESP_SLVERR);
        chk("wake idle", wake_line, 1'b1);
        wr(`GPWL_IDX_PORT_CFG, 8'h00);
        wr(`GPWL_IDX_PORT_CFG + 10'h001, 8'h03);
        wr(`GPWL_IDX_DATA1, 8'hff);
        rchk("data1", `GPWL_IDX_DATA1, 8'h03);
        chk("od off", {port_drive.oe[0], port_drive.level[0]}, 2'b00);
        wr(`GPWL_IDX_DATA1, 8'h00);
        chk("od on", {port_drive.oe[0], port_drive.level[0]}, 2'b10);
        wr(`GPWL_IDX_PORT_CFG, 8'h82);
        chk("pp inv", {port_drive.oe[0], port_drive.level[0]}, 2'b11);
        pins <= 12'h007;
        idle(4);
        pins <= 12'h105;
        idle(4);
        rchk("st2", `GPWL_IDX_ST2, 8'h06);
        rchk("st3", `GPWL_IDX_ST3, 8'h01);
        wr(`GPWL_IDX_EN2, 8'h04);
        idle(4);
        chk("no global", wake_line, 1'b1);
        wr(`GPWL_IDX_GEN, 8'h01);
        idle(4);
        chk("wake on", wake_line, 1'b0);
        wr(`GPWL_IDX_ST2, 8'h00);
        rchk("zero kept", `GPWL_IDX_ST2, 8'h06);
        wr(`GPWL_IDX_WAKE_CFG, 8'h81);
        idle(2);
        chk("wake high", {wake_event_out.oe, wake_event_out.level}, 2'b11);
        wr(`GPWL_IDX_WAKE_CFG, 8'h00);
        wr(`GPWL_IDX_ST2, 8'h02);
        idle(4);
        chk("still on", wake_line, 1'b0);
        wr(`GPWL_IDX_ST2, 8'h04);
        idle(4);
        chk("wake off", wake_line, 1'b1);
        wr(`GPWL_IDX_DUAL, 8'h01);
        wr(`GPWL_IDX_PORT_CFG + 10'h009, 8'h03);
        wr(`GPWL_IDX_PORT_CFG + 10'h00a, 8'h03);
        wr(`GPWL_IDX_ST3, 8'h0f);
        for (int k = 0; k < 2; k++) begin
            pins <= pins ^ 12'h200;
            idle(4);
            rchk("dual st3", `GPWL_IDX_ST3, 8'h02);
            rchk("dual misc", `GPWL_IDX_MISC, 8'h01);
            wr(`GPWL_IDX_ST3, 8'h02);
            wr(`GPWL_IDX_MISC, 8'h01);
        end
        pins <= 12'h505;
        idle(4);
        rchk("misc only", `GPWL_IDX_MISC, 8'h02);
        rchk("no st3", `GPWL_IDX_ST3, 8'h00);
        rchk("data2", `GPWL_IDX_DATA2, 8'h03);
        for (int i = 0; i < 5; i++) begin
            src[i] <= ~src[i];
            idle(1);
            src[i] <= ~src[i];
            idle(4);
            rchk("source", `GPWL_IDX_ST1, 8'h01 << i);
            wr(`GPWL_IDX_ST1, 8'h01 << i);
        end
        ce <= 1'b0;
        idle(3);
        ce <= 1'b1;
        wr(`GPWL_IDX_KEY_CODE, 8'h5a);
        kframe(1'b1, 5);
        kframe(1'b1, 11);
        rchk("key hit", `GPWL_IDX_ST1, 8'h24);
        wr(`GPWL_IDX_ST1, 8'hff);
        kframe(1'b0, 11);
        rchk("bad parity", `GPWL_IDX_ST1, 8'h04);
        wr(`GPWL_IDX_ST1, 8'hff);
        wr(`GPWL_IDX_SLOW_CFG, 8'h02);
        kframe(1'b1, 11);
        rchk("key off", `GPWL_IDX_ST1, 8'h04);
        wr(`GPWL_IDX_SLOW_CFG, 8'h00);
        wr(`GPWL_IDX_ST1, 8'hff);
        wr(`GPWL_IDX_EN1, 8'h20);
        kframe(1'b1, 11);
        chk("key wake", wake_line, 1'b0);
        aresetn <= 1'b0;
        idle(2);
        aresetn <= 1'b1;
        rchk("code kept", `GPWL_IDX_KEY_CODE, 8'h5a);
        standby_por_n <= 1'b0;
        idle(2);
        standby_por_n <= 1'b1;
        rchk("code clear", `GPWL_IDX_KEY_CODE, 8'h00);
        wrap_up();
    end
endmodule : gpwl_wake_logic_tb
`default_nettype wire
